/* design/trigger_encoder_unit.sv */
// Purpose: Trigger origin selection, trigger shaping and three encoder counters.
// Assumes: Inputs synchronous-ish to pclk, resynchronised here; APB register access.
// Notes: One measurement cycle every MEAS_PERIOD_CYCLES+1 clocks; a value
//        is released on a cycle boundary while triggering is armed.
// How it works
// - Exactly one trigger origin drives acquisition
// - Software origin pulses per soft command only
// - Encoder three origin needs third encoder enabled
// - Input point averages exclude latest samples
// - Output point averages include latest samples
// - Trigger point resets to value recording
// - Edge/level kind applies to pins only
// - High polarity: rising edge, high level
// - Low polarity: falling edge, low level
// - Each pulse releases programmed value count
// - Infinite count runs output without end
// - Logic family affects aux pin only
// - Encoder trigger only inside 32-bit window
// - Step zero fires on every window position
// - Trigger positions are step multiples
// - Interpolation depth one, two or four
// - Index mark none, once or every
// - Preset loads on mark or software
// - Preset write clears first-mark detection
// - Soft load/clear only with mark none
// - Encoders A and B wrap to zero
// - Third enable forces marks A, B none
// - Counter clear waits for trigger edge
`timescale 1ns/1ps
`include "trigger_encoder_regs.svh"

module trigger_encoder_unit
  import trigger_encoder_pkg::*;
#(
  parameter int ENCODERS = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic diff_sync_pin,
  input wire logic aux_trigger_pin,
  input wire logic [2:0] enc_track_a,
  input wire logic [2:0] enc_track_b,
  input wire logic [2:0] enc_index,
  output logic value_release,
  output logic average_include_latest,
  output logic aux_family_htl
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] step_of(input logic [1:0] depth);
    step_of = (depth == INTERP_4) ? 32'h0000_0004 :
              (depth == INTERP_2) ? 32'h0000_0002 : 32'h0000_0001;
  endfunction

  // True when pos lies in [lo,hi] and is a multiple of step (step 0: any).
  function automatic logic pos_hit(input logic [31:0] pos, input logic [31:0] lo,
                                   input logic [31:0] hi, input logic [31:0] step);
    pos_hit = (pos >= lo) && (pos <= hi) && ((step == 32'h0000_0000) ||
              ((pos % step) == 32'h0000_0000));
  endfunction

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [10:0] sync_1, sync_2, sync_3;
  logic [10:0] next_sync_1, next_sync_2, next_sync_3;
  always_comb begin
    next_sync_1 = {enc_index, enc_track_b, enc_track_a, aux_trigger_pin, diff_sync_pin};
    next_sync_2 = sync_1;
    next_sync_3 = sync_2;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_1 <= 11'h000;
      sync_2 <= 11'h000;
      sync_3 <= 11'h000;
    end else begin
      sync_1 <= next_sync_1;
      sync_2 <= next_sync_2;
      sync_3 <= next_sync_3;
    end
  end
  wire logic sync_now = sync_2[0];
  wire logic aux_now = sync_2[1];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] trig_ctrl, values_per_trigger, window_lower, window_upper, step_interval;
  logic [31:0] enc_ctrl;
  logic [31:0] preset [3];
  logic [31:0] wrap_limit [2];
  logic [31:0] count [3];
  logic [2:0] mark_seen;
  logic [31:0] next_trig_ctrl, next_values_per_trigger, next_window_lower;
  logic [31:0] next_window_upper, next_step_interval, next_enc_ctrl;
  logic [31:0] next_preset [3];
  logic [31:0] next_wrap_limit [2];
  logic [31:0] next_count [3];
  logic [2:0] next_mark_seen;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic soft_trigger_cmd, next_soft_trigger_cmd;
  logic [1:0] clear_pending, next_clear_pending;

  wire logic setup = psel && !penable;
  wire logic wr = psel && penable && pwrite && pready;
  wire logic third_counter_enable = enc_ctrl[`EC_THIRD_ENABLE_BIT];

  function automatic logic [1:0] mark_of(input logic [31:0] ec, input int i);
    mark_of = (i == 2) ? MARK_NONE : ec[`EC_MARK_LSB + 2*i +: 2];
  endfunction

  // Active (cycle-boundary) copies of trigger settings.
  logic [31:0] act_ctrl, act_count, next_act_ctrl, next_act_count;
  logic boundary;
  wire origin_t origin = origin_t'(act_ctrl[`TC_ORIGIN_LSB +: 3]);

  logic fire;
  logic [31:0] remaining, next_remaining;
  run_t run, next_run;
  logic prev_pin, next_prev_pin;
  logic [15:0] period, next_period;
  logic [31:0] meas_count, timestamp, next_meas_count, next_timestamp;
  logic next_value_release, next_average_include_latest, next_aux_family_htl;

  always_comb begin
    int i;
    logic [2:0] a_new, b_new, idx_new, a_old, b_old, idx_old;
    logic [31:0] delta;
    i = 0;
    delta = 32'h0000_0000;
    next_trig_ctrl = trig_ctrl;
    next_values_per_trigger = values_per_trigger;
    next_window_lower = window_lower;
    next_window_upper = window_upper;
    next_step_interval = step_interval;
    next_enc_ctrl = enc_ctrl;
    next_preset = preset;
    next_wrap_limit = wrap_limit;
    next_count = count;
    next_mark_seen = mark_seen;
    next_soft_trigger_cmd = 1'b0;
    next_clear_pending = clear_pending;
    a_new = sync_2[4:2];
    b_new = sync_2[7:5];
    idx_new = sync_2[10:8];
    a_old = sync_3[4:2];
    b_old = sync_3[7:5];
    idx_old = sync_3[10:8];
    // Quadrature decode with selectable interpolation.
    for (i = 0; i < ENCODERS; i++) begin
      delta = 32'h0000_0000;
      if (a_new[i] != a_old[i]) begin
        if (a_new[i] ^ b_new[i]) delta = 32'h0000_0001;
        else delta = 32'hFFFF_FFFF;
      end else if (b_new[i] != b_old[i]) begin
        if (a_new[i] ~^ b_new[i]) delta = 32'h0000_0001;
        else delta = 32'hFFFF_FFFF;
      end
      // Depth 1 counts rising A only, 2 counts both A edges, 4 all edges.
      case (interp_t'(enc_ctrl[`EC_INTERP_LSB + 2*i +: 2]))
        INTERP_1: if (!(a_new[i] && !a_old[i])) delta = 32'h0000_0000;
        INTERP_2: if (a_new[i] == a_old[i]) delta = 32'h0000_0000;
        default: ;
      endcase
      if (step_of(enc_ctrl[`EC_INTERP_LSB + 2*i +: 2]) == 32'h0000_0000) delta = 32'h0000_0000;
      if (i < 2 && delta == 32'h0000_0001 && count[i] >= wrap_limit[i]) begin
        next_count[i] = 32'h0000_0000;
      end else if (i < 2 && delta == 32'hFFFF_FFFF && count[i] == 32'h0000_0000) begin
        next_count[i] = wrap_limit[i];
      end else begin
        next_count[i] = count[i] + delta;
      end
      if (idx_new[i] && !idx_old[i]) begin
        if (mark_of(enc_ctrl, i) == MARK_EVER ||
            (mark_of(enc_ctrl, i) == MARK_ONCE && !mark_seen[i])) begin
          next_count[i] = preset[i];
          next_mark_seen[i] = 1'b1;
        end
      end
    end
    if (wr) begin
      case (paddr)
        `OFS_TRIG_CTRL: next_trig_ctrl = {24'h00_0000, pwdata[7:0]};
        `OFS_VALUES_PER_TRIGGER: next_values_per_trigger = pwdata;
        `OFS_WINDOW_LOWER: next_window_lower = pwdata;
        `OFS_WINDOW_UPPER: next_window_upper = pwdata;
        `OFS_STEP_INTERVAL: next_step_interval = pwdata;
        `OFS_ENC_CTRL: begin
          next_enc_ctrl = {19'h0_0000, pwdata[12:0]};
          if (pwdata[`EC_THIRD_ENABLE_BIT]) next_enc_ctrl[11:8] = 4'h0;
        end
        `OFS_CMD: begin
          next_soft_trigger_cmd = pwdata[`CMD_SOFT_TRIGGER_BIT];
          next_clear_pending = clear_pending | pwdata[13:12];
          for (i = 0; i < 3; i++) begin
            // Ignored silently unless the mark effect is none.
            if (mark_of(enc_ctrl, i) == MARK_NONE) begin
              if (pwdata[`CMD_PRESET_LOAD_LSB + i]) next_count[i] = preset[i];
              if (pwdata[`CMD_DETECT_CLEAR_LSB + i]) next_mark_seen[i] = 1'b0;
            end
          end
        end
        default: begin
          for (i = 0; i < 3; i++) begin
            if (paddr == `OFS_PRESET_A + 12'(4*i)) begin
              next_preset[i] = pwdata;
              next_mark_seen[i] = 1'b0;
            end
            if (i < 2 && paddr == `OFS_WRAP_A + 12'(4*i)) next_wrap_limit[i] = pwdata;
          end
        end
      endcase
    end
    if (fire) next_clear_pending = 2'b00;
  end

  // Read mux and APB answer: no wait state, pready high in the first access cycle.
  always_comb begin
    int i;
    i = 0;
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        `OFS_TRIG_CTRL: next_prdata = trig_ctrl;
        `OFS_VALUES_PER_TRIGGER: next_prdata = values_per_trigger;
        `OFS_CMD: next_prdata = 32'h0000_0000;
        `OFS_WINDOW_LOWER: next_prdata = window_lower;
        `OFS_WINDOW_UPPER: next_prdata = window_upper;
        `OFS_STEP_INTERVAL: next_prdata = step_interval;
        `OFS_ENC_CTRL: next_prdata = enc_ctrl;
        `OFS_STATUS: next_prdata = {27'h000_0000, mark_seen, run};
        `OFS_MEAS_COUNT: next_prdata = meas_count;
        `OFS_TIMESTAMP: next_prdata = timestamp;
        default: begin
          next_pslverr = 1'b1;
          for (i = 0; i < 3; i++) begin
            if (paddr == `OFS_PRESET_A + 12'(4*i)) begin
              next_prdata = preset[i];
              next_pslverr = 1'b0;
            end
            if (paddr == `OFS_COUNT_A + 12'(4*i)) begin
              next_prdata = count[i];
              next_pslverr = 1'b0;
            end
            if (i < 2 && paddr == `OFS_WRAP_A + 12'(4*i)) begin
              next_prdata = wrap_limit[i];
              next_pslverr = 1'b0;
            end
          end
        end
      endcase
    end else if (setup) begin
      next_pslverr = !(paddr inside {`OFS_TRIG_CTRL, `OFS_VALUES_PER_TRIGGER, `OFS_CMD,
        `OFS_WINDOW_LOWER, `OFS_WINDOW_UPPER, `OFS_STEP_INTERVAL, `OFS_ENC_CTRL,
        `OFS_PRESET_A, `OFS_PRESET_A + 12'h004, `OFS_PRESET_A + 12'h008,
        `OFS_WRAP_A, `OFS_WRAP_A + 12'h004});
    end
  end

  // ---------------------------------------------------------------
  // Trigger engine
  // ---------------------------------------------------------------
  always_comb begin
    logic pin, active, edge_hit, level_mode;
    logic [31:0] pos;
    pin = 1'b0;
    active = 1'b0;
    edge_hit = 1'b0;
    level_mode = 1'b0;
    pos = 32'h0000_0000;
    boundary = (period == `MEAS_PERIOD_CYCLES);
    next_period = boundary ? 16'h0000 : period + 16'h0001;
    next_act_ctrl = boundary ? trig_ctrl : act_ctrl;
    next_act_count = boundary ? values_per_trigger : act_count;
    pin = (origin == ORIGIN_SYNC) ? sync_now : aux_now;
    next_prev_pin = pin;
    // Polarity picks the edge direction and active level.
    active = act_ctrl[`TC_POLARITY_BIT] ? pin : !pin;
    edge_hit = act_ctrl[`TC_POLARITY_BIT] ? (pin && !prev_pin) : (!pin && prev_pin);
    level_mode = act_ctrl[`TC_KIND_BIT] &&
                 (origin == ORIGIN_SYNC || origin == ORIGIN_AUX);
    pos = 32'h0000_0000;
    fire = 1'b0;
    case (origin)
      ORIGIN_SYNC, ORIGIN_AUX: fire = !level_mode && edge_hit;
      ORIGIN_SOFT: fire = soft_trigger_cmd;
      ORIGIN_ENC_A: pos = count[0];
      ORIGIN_ENC_B: pos = count[1];
      ORIGIN_ENC_C: pos = count[2];
      default: fire = 1'b0;
    endcase
    if (origin == ORIGIN_ENC_A || origin == ORIGIN_ENC_B ||
        (origin == ORIGIN_ENC_C && third_counter_enable)) begin
      // Fire at every cycle boundary while the position is a hit inside the window.
      fire = pos_hit(pos, window_lower, window_upper, step_interval) && boundary;
    end
    next_run = run;
    next_remaining = remaining;
    next_value_release = 1'b0;
    if (act_count == `COUNT_NONE || origin == ORIGIN_NONE) begin
      next_run = RUN_IDLE;
    end else if (level_mode) begin
      next_run = active ? RUN_LEVEL : RUN_IDLE;
      next_value_release = active && boundary;
    end else begin
      if (fire) begin
        next_run = (act_count == `COUNT_INFINITE) ? RUN_FOREVER : RUN_COUNT;
        next_remaining = (act_count == `COUNT_INFINITE) ? remaining : act_count;
      end
      if (boundary) begin
        case (next_run)
          RUN_COUNT: begin
            next_value_release = 1'b1;
            next_remaining = next_remaining - 32'h0000_0001;
            if (next_remaining == 32'h0000_0000) next_run = RUN_IDLE;
          end
          RUN_FOREVER: next_value_release = 1'b1;
          default: ;
        endcase
      end
    end
    // Recording point holds older averages; output point uses latest.
    next_average_include_latest = act_ctrl[`TC_POINT_BIT];
    next_aux_family_htl = act_ctrl[`TC_FAMILY_BIT];
    next_timestamp = (fire && clear_pending[0]) ? 32'h0000_0000 : timestamp + 32'h0000_0001;
    next_meas_count = (fire && clear_pending[1]) ? 32'h0000_0000 :
                      meas_count + {31'h0000_0000, value_release};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ctrl <= `TC_RESET_VAL;
      act_ctrl <= `TC_RESET_VAL;
      values_per_trigger <= `COUNT_NONE;
      act_count <= `COUNT_NONE;
      window_lower <= 32'h0000_0000;
      window_upper <= 32'h0000_0000;
      step_interval <= 32'h0000_0000;
      enc_ctrl <= 32'h0000_0000;
      preset <= '{default: 32'h0000_0000};
      wrap_limit <= '{default: 32'hFFFF_FFFF};
      count <= '{default: 32'h0000_0000};
      mark_seen <= 3'b000;
      soft_trigger_cmd <= 1'b0;
      clear_pending <= 2'b00;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      period <= 16'h0000;
      run <= RUN_IDLE;
      remaining <= 32'h0000_0000;
      prev_pin <= 1'b0;
      value_release <= 1'b0;
      average_include_latest <= 1'b0;
      aux_family_htl <= 1'b0;
      timestamp <= 32'h0000_0000;
      meas_count <= 32'h0000_0000;
    end else begin
      trig_ctrl <= next_trig_ctrl;
      act_ctrl <= next_act_ctrl;
      values_per_trigger <= next_values_per_trigger;
      act_count <= next_act_count;
      window_lower <= next_window_lower;
      window_upper <= next_window_upper;
      step_interval <= next_step_interval;
      enc_ctrl <= next_enc_ctrl;
      preset <= next_preset;
      wrap_limit <= next_wrap_limit;
      count <= next_count;
      mark_seen <= next_mark_seen;
      soft_trigger_cmd <= next_soft_trigger_cmd;
      clear_pending <= next_clear_pending;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      period <= next_period;
      run <= next_run;
      remaining <= next_remaining;
      prev_pin <= next_prev_pin;
      value_release <= next_value_release;
      average_include_latest <= next_average_include_latest;
      aux_family_htl <= next_aux_family_htl;
      timestamp <= next_timestamp;
      meas_count <= next_meas_count;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_wrap_a;
    @(posedge pclk) disable iff (!presetn)
    (count[0] == wrap_limit[0] && sync_2[2] && !sync_3[2] && sync_2[5] == 1'b0 &&
     enc_ctrl[1:0] == INTERP_1 && !(sync_2[8] && !sync_3[8]) && !wr) |=> count[0] == 0;
  endproperty
  a_wrap_a: assert property (p_wrap_a) else $error("encoder A did not wrap");
  property p_third;
    @(posedge pclk) disable iff (!presetn) third_counter_enable |-> enc_ctrl[11:8] == 4'h0;
  endproperty
  a_third: assert property (p_third) else $error("marks not forced none");
  property p_none_idle;
    @(posedge pclk) disable iff (!presetn) (act_count == `COUNT_NONE) |=> !value_release;
  endproperty
  a_none_idle: assert property (p_none_idle) else $error("release with count none");
  property p_soft;
    @(posedge pclk) disable iff (!presetn)
    (origin == ORIGIN_SOFT && !soft_trigger_cmd && run == RUN_IDLE) |=> run == RUN_IDLE;
  endproperty
  a_soft: assert property (p_soft) else $error("soft origin ran uncommanded");
  property p_preset_clear;
    @(posedge pclk) disable iff (!presetn) (wr && paddr == `OFS_PRESET_A) |=> !mark_seen[0];
  endproperty
  a_preset_clear: assert property (p_preset_clear) else $error("mark state kept");
  property p_apply;
    @(posedge pclk) disable iff (!presetn) !boundary |=> $stable(act_ctrl);
  endproperty
  a_apply: assert property (p_apply) else $error("settings changed mid cycle");
  property p_enc_c;
    @(posedge pclk) disable iff (!presetn)
    (origin == ORIGIN_ENC_C && !third_counter_enable) |-> !fire;
  endproperty
  a_enc_c: assert property (p_enc_c) else $error("disabled encoder fired");
  property p_point;
    @(posedge pclk) disable iff (!presetn) ##1 average_include_latest == $past(act_ctrl[4]);
  endproperty
  a_point: assert property (p_point) else $error("averaging point wrong");
endmodule

/* design/trigger_encoder_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Definitions only.
`ifndef TRIGGER_ENCODER_REGS_SVH
`define TRIGGER_ENCODER_REGS_SVH

`define OFS_TRIG_CTRL 12'h000
`define OFS_VALUES_PER_TRIGGER 12'h004
`define OFS_CMD 12'h008
`define OFS_WINDOW_LOWER 12'h00C
`define OFS_WINDOW_UPPER 12'h010
`define OFS_STEP_INTERVAL 12'h014
`define OFS_ENC_CTRL 12'h018
`define OFS_PRESET_A 12'h020
`define OFS_WRAP_A 12'h030
`define OFS_COUNT_A 12'h040
`define OFS_STATUS 12'h050
`define OFS_MEAS_COUNT 12'h054
`define OFS_TIMESTAMP 12'h058

`define TC_ORIGIN_LSB 0
`define TC_POINT_BIT 4
`define TC_KIND_BIT 5
`define TC_POLARITY_BIT 6
`define TC_FAMILY_BIT 7
`define TC_RESET_VAL 32'h0000_0000

`define CMD_SOFT_TRIGGER_BIT 0
`define CMD_PRESET_LOAD_LSB 4
`define CMD_DETECT_CLEAR_LSB 8
`define CMD_CLEAR_TIMESTAMP_BIT 12
`define CMD_CLEAR_MEASCNT_BIT 13

`define EC_INTERP_LSB 0
`define EC_MARK_LSB 8
`define EC_THIRD_ENABLE_BIT 12

`define COUNT_NONE 32'h0000_0000
`define COUNT_INFINITE 32'hFFFF_FFFF
`define MEAS_PERIOD_CYCLES 16'h00FF

`endif

/* design/trigger_encoder_pkg.sv */
// Purpose: Types shared by the trigger and encoder logic.
// Assumes: Nothing beyond SystemVerilog.
// Notes: Offsets and constants live in the regs header.
package trigger_encoder_pkg;
  typedef enum logic [2:0] {
    ORIGIN_NONE = 3'b000,
    ORIGIN_SYNC = 3'b001,
    ORIGIN_AUX = 3'b010,
    ORIGIN_SOFT = 3'b011,
    ORIGIN_ENC_A = 3'b100,
    ORIGIN_ENC_B = 3'b101,
    ORIGIN_ENC_C = 3'b110
  } origin_t;
  typedef enum logic [1:0] {
    MARK_NONE = 2'b00,
    MARK_ONCE = 2'b01,
    MARK_EVER = 2'b10
  } mark_effect_t;
  typedef enum logic [1:0] {
    INTERP_1 = 2'b00,
    INTERP_2 = 2'b01,
    INTERP_4 = 2'b10
  } interp_t;
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_COUNT = 2'b01,
    RUN_FOREVER = 2'b10,
    RUN_LEVEL = 2'b11
  } run_t;
endpackage

/* testbench/trigger_source_model.sv */
// Purpose: Far-side model of the trigger pins and quadrature encoders.
// Assumes: Pins change just after a rising edge.
// Notes: Quadrature steps are four clocks apart so the input resync keeps up.
`timescale 1ns/1ps
module trigger_source_model (
  input wire logic pclk,
  output logic diff_sync_pin,
  output logic aux_trigger_pin,
  output logic [2:0] enc_track_a,
  output logic [2:0] enc_track_b,
  output logic [2:0] enc_index
);
  logic [1:0] ph [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  initial begin
    diff_sync_pin = 1'b0;
    aux_trigger_pin = 1'b0;
    enc_track_a = 3'h0;
    enc_track_b = 3'h0;
    enc_index = 3'h0;
  end
  task set_pin(input int o, input logic v);
    @(posedge pclk);
    if (o == 1) diff_sync_pin <= v;
    else aux_trigger_pin <= v;
  endtask
  task quad(input int e);
    for (int i = 0; i < 4; i++) begin
      repeat (4) @(posedge pclk);
      enc_track_a[e] <= ph[i][1];
      enc_track_b[e] <= ph[i][0];
    end
  endtask
endmodule

/* testbench/tb_trigger_encoder_unit.sv */
// Purpose: Self-checking bench for the trigger and encoder unit.
// Assumes: Settings are taken at a measurement boundary every 256 clocks.
// Notes: Release counts are taken over whole windows of boundaries.
`timescale 1ns/1ps
`include "trigger_encoder_regs.svh"
module tb_trigger_encoder_unit;
  import trigger_encoder_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic value_release, average_include_latest, aux_family_htl;
  logic diff_sync_pin, aux_trigger_pin;
  logic [2:0] enc_track_a, enc_track_b, enc_index;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, x;
  int miscompares = 0;
  int check_count = 0;
  int n;
  trigger_encoder_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .diff_sync_pin(diff_sync_pin), .aux_trigger_pin(aux_trigger_pin),
    .enc_track_a(enc_track_a), .enc_track_b(enc_track_b), .enc_index(enc_index),
    .value_release(value_release), .average_include_latest(average_include_latest),
    .aux_family_htl(aux_family_htl));
  trigger_source_model m (.pclk(pclk), .diff_sync_pin(diff_sync_pin),
    .aux_trigger_pin(aux_trigger_pin), .enc_track_a(enc_track_a),
    .enc_track_b(enc_track_b), .enc_index(enc_index));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task finish_test;
    $display("Checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] xp, input logic [31:0] g);
    check_count++;
    if (g !== xp) begin
      $display("Error %s expected %h seen %h", nm, xp, g);
      miscompares++;
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      finish_test();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task count_rel(input int c);
    n = 0;
    repeat (c) begin
      @(posedge pclk);
      if (value_release === 1'b1) n++;
    end
  endtask
  task t_reset;
    apb(0, `OFS_TRIG_CTRL, 0);
    chk("trig_ctrl", `TC_RESET_VAL, q);
    chk("include_latest", 0, {31'h0, average_include_latest});
    apb(0, 12'h0FC, 0);
    chk("slverr", 1, {31'h0, e});
    chk("unmapped", 0, q);
  endtask
  task t_soft;
    apb(1, `OFS_VALUES_PER_TRIGGER, 3);
    apb(1, `OFS_TRIG_CTRL, 32'(ORIGIN_SOFT));
    count_rel(300);
    apb(1, `OFS_CMD, 1);
    count_rel(1280);
    chk("soft_burst", 3, n);
    count_rel(600);
    chk("soft_idle", 0, n);
    apb(1, `OFS_VALUES_PER_TRIGGER, `COUNT_NONE);
    count_rel(300);
    apb(1, `OFS_CMD, 1);
    count_rel(600);
    chk("count_none", 0, n);
  endtask
  task t_pins;
    for (int o = 1; o <= 2; o++) begin
      for (int p = 0; p <= 1; p++) begin
        apb(1, `OFS_VALUES_PER_TRIGGER, 2);
        apb(1, `OFS_TRIG_CTRL, o | (p << 6));
        count_rel(300);
        m.set_pin(o, !p);
        count_rel(20);
        m.set_pin(o, p);
        count_rel(1024);
        chk("pin_edge", 2, n);
      end
    end
    apb(1, `OFS_TRIG_CTRL, 32'h0000_0062);
    count_rel(300);
    m.set_pin(2, 1'b1);
    count_rel(8);
    count_rel(768);
    chk("level_high", 3, n);
    m.set_pin(2, 1'b0);
    count_rel(8);
    count_rel(512);
    chk("level_low", 0, n);
    apb(1, `OFS_TRIG_CTRL, 32'h0000_0092);
    count_rel(300);
    chk("family", 1, {31'h0, aux_family_htl});
    chk("include_latest", 1, {31'h0, average_include_latest});
  endtask
  task t_enc;
    apb(1, `OFS_ENC_CTRL, 0);
    apb(1, `OFS_WRAP_A, 32'hFFFF_FFFF);
    apb(1, `OFS_PRESET_A, 32'h1234_5678);
    apb(1, `OFS_CMD, 32'h0000_0010);
    apb(0, `OFS_COUNT_A, 0);
    chk("preset_load", 32'h1234_5678, q);
    apb(1, `OFS_ENC_CTRL, 32'h0000_0100);
    apb(1, `OFS_PRESET_A, 32'h0000_0100);
    apb(1, `OFS_CMD, 32'h0000_0010);
    apb(0, `OFS_COUNT_A, 0);
    chk("load_ignored", 32'h1234_5678, q);
    apb(1, `OFS_ENC_CTRL, 32'h0000_1100);
    apb(0, `OFS_ENC_CTRL, 0);
    chk("marks_forced", 0, {28'h0, q[11:8]});
    for (int d = 0; d < 3; d++) begin
      apb(1, `OFS_ENC_CTRL, d);
      apb(0, `OFS_COUNT_A, 0);
      x = q;
      m.quad(0);
      count_rel(10);
      apb(0, `OFS_COUNT_A, 0);
      x = q - x;
      chk("depth", 1, {31'h0, (x == (1 << d)) || (x == -(1 << d))});
    end
    apb(1, `OFS_VALUES_PER_TRIGGER, 1);
    apb(1, `OFS_WINDOW_LOWER, 5);
    apb(1, `OFS_WINDOW_UPPER, 35);
    apb(1, `OFS_STEP_INTERVAL, 10);
    apb(1, `OFS_PRESET_A, 20);
    apb(1, `OFS_CMD, 32'h0000_0010);
    apb(1, `OFS_TRIG_CTRL, 4);
    count_rel(300);
    count_rel(768);
    chk("enc_hit", 3, n);
    apb(1, `OFS_PRESET_A, 25);
    apb(1, `OFS_CMD, 32'h0000_0010);
    count_rel(300);
    count_rel(512);
    chk("enc_miss", 0, n);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_soft();
    t_pins();
    t_enc();
    finish_test();
  end
endmodule
